/* File: src/spmc_pkg.sv */
// shared constants and types for the sensor power and mode control link
package spmc_pkg;
  localparam int unsigned SPMC_CLK_HZ = 20_000_000;
  // standby exit budget, in ms as printed, and its cycle count
  localparam int unsigned SPMC_WAKE_MS = 100;
  localparam longint unsigned SPMC_WAKE_CYC_L =
    (longint'(SPMC_WAKE_MS) * SPMC_CLK_HZ) / 1000;
  // internal wake sequence: power settle then reset hold
  localparam int unsigned SPMC_SETTLE_DEF = 1000;
  localparam int unsigned SPMC_RST_HOLD = 16;
  localparam int unsigned SPMC_FRAME_FPS_MAX = 30;
  localparam int unsigned SPMC_SER_KHZ_MAX = 400;
  // serial command period: least time rounds up
  localparam int unsigned SPMC_SER_CYC =
    (SPMC_CLK_HZ + SPMC_SER_KHZ_MAX * 1000 - 1) / (SPMC_SER_KHZ_MAX * 1000);
  localparam int unsigned SPMC_PIX_W = 10;
  localparam int unsigned SPMC_CMD_W = 8;
  localparam int unsigned SPMC_CNT_W = 24;
  localparam logic [6:0] SPMC_ADDR_LO = 7'h5d;
  localparam logic [6:0] SPMC_ADDR_HI = 7'h5c;
  localparam logic [1:0] SPMC_DIV_1 = 2'h0;
  localparam logic [1:0] SPMC_DIV_2 = 2'h1;
  localparam logic [1:0] SPMC_DIV_4 = 2'h2;
  // serial command opcodes
  localparam logic [7:0] SPMC_OP_RESET = 8'h01;
  localparam logic [7:0] SPMC_OP_REC_A = 8'h10;
  localparam logic [7:0] SPMC_OP_REC_B = 8'h11;
  localparam logic [7:0] SPMC_OP_REC_IDLE = 8'h12;
  localparam logic [7:0] SPMC_OP_VIEW = 8'h20;
  localparam logic [7:0] SPMC_OP_SNAP = 8'h21;
  localparam logic [7:0] SPMC_OP_STOP = 8'h22;
  localparam logic [7:0] SPMC_OP_DIV = 8'h30;
  localparam logic [7:0] SPMC_OP_NFRM = 8'h31;
  localparam logic [7:0] SPMC_OP_EXPO = 8'h32;
  localparam logic [7:0] SPMC_OP_LINES = 8'h33;
  localparam logic [7:0] SPMC_OP_FAST = 8'h34;
  localparam logic [7:0] SPMC_OP_BIN = 8'h35;
  localparam logic [7:0] SPMC_OP_VSTART = 8'h36;
  localparam int unsigned SPMC_FAST_OVH = 4;
  localparam int unsigned SPMC_LINE_CYC = 64;
  typedef enum logic [2:0] {
    SPMC_ST_STANDBY = 3'b000,
    SPMC_ST_SETTLE = 3'b001,
    SPMC_ST_RESET = 3'b010,
    SPMC_ST_READY = 3'b011,
    SPMC_ST_EXPOSE = 3'b100,
    SPMC_ST_STREAM = 3'b101
  } spmc_state_t;
  typedef enum logic [1:0] {
    SPMC_REC_A = 2'b00,
    SPMC_REC_B = 2'b01,
    SPMC_REC_IDLE = 2'b10
  } spmc_rec_t;
endpackage

/* File: src/spmc_link_if.sv */
// pin-level link between host controller and sensor control
`timescale 1ns/100ps
`default_nettype none
interface spmc_link_if;
  import spmc_pkg::*;
  logic standby;
  logic reset_b;
  logic reset_drv;
  logic addr_sel;
  logic cmd_valid;
  logic [7:0] cmd_op;
  logic [spmc_pkg::SPMC_CNT_W-1:0] cmd_arg;
  logic [6:0] cmd_addr;
  logic cmd_ack;
  logic cmd_ack_oe;
  logic frame_valid;
  logic line_valid;
  logic [spmc_pkg::SPMC_PIX_W-1:0] pix_data;
  logic out_oe;
  logic ready;
  modport dev (input standby, reset_b, reset_drv, addr_sel, cmd_valid,
    cmd_op, cmd_arg, cmd_addr, output cmd_ack, cmd_ack_oe, frame_valid,
    line_valid, pix_data, out_oe, ready);
  modport host (output standby, reset_b, reset_drv, addr_sel, cmd_valid,
    cmd_op, cmd_arg, cmd_addr, input cmd_ack, cmd_ack_oe, frame_valid,
    line_valid, pix_data, out_oe, ready);
endinterface
`default_nettype wire

/* File: src/spmc_dev.sv */
// sensor end: standby, reset merge, records, readout modes, binning
// Contract
// [RQ1] no standby, no reset: commands and images
// [RQ2] snapshot and preview set only by programming
// [RQ3] standby tri-states outputs, core off, low bias
// [RQ4] settings undefined after standby; reset mandatory
// [RQ5] standby exit completes within 100 ms
// [RQ6] host releases standby only after reset
// [RQ7] idle record: slow clock, zero analog bias
// [RQ8] idle record: no capture, no output
// [RQ9] viewfinder: continuous subsampled low-power stream
// [RQ10] viewfinder logic clock divide two or four
// [RQ11] snapshot: full frames, programmed count
// [RQ12] snapshot entry: optional fast line reset
// [RQ13] first frame within exposure plus overhead
// [RQ14] snapshot window lines and start programmable
// [RQ15] power-on detector resets on power rise; code fires it only while standby is low
// [RQ16] reset from detector, pin, or command
// [RQ17] binning sums same-colour pixel pairs
// [RQ18] binning advised only with read-two-skip-two
// [RQ19] serial commands no faster than 400 kHz
// [RQ20] address pin picks serial device address
// [RQ21] reset asserts async, releases synchronously
`timescale 1ns/100ps
`default_nettype none
module spmc_dev
  import spmc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SPMC_SETTLE_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  spmc_link_if.dev lnk,
  input wire logic power_good,
  input wire logic [SPMC_PIX_W-1:0] pix_in,
  output logic core_power_on,
  output logic [1:0] analog_bias,
  output logic [1:0] clk_div,
  output logic view_mode,
  output logic snap_mode,
  output logic fast_reset
);
  spmc_state_t st_q, st_d;
  spmc_rec_t rec_q, rec_d;
  logic [SPMC_CNT_W-1:0] cnt_q, cnt_d;
  logic [SPMC_CNT_W-1:0] nfrm_q, nfrm_d, expo_q, expo_d;
  logic [SPMC_CNT_W-1:0] lines_q, lines_d, vstart_q, vstart_d;
  logic [SPMC_CNT_W-1:0] frm_q, frm_d, line_q, line_d;
  logic [1:0] div_q, div_d, tick_q, tick_d;
  logic view_q, view_d, snap_q, snap_d, fast_q, fast_d, bin_q, bin_d;
  logic ack_q, ack_d, lv_q, lv_d, half_q, half_d;
  logic [SPMC_PIX_W-1:0] pix_q, pix_d, acc_q, acc_d;
  logic pg_q, por_req, cmd_rst, int_rst_b, rst_meta_q, rst_sync_q;
  logic hit, active, tick;
  logic [6:0] my_addr;
  // power-on detector: new power while standby is low fires a reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= power_good;
    end
  end
  assign por_req = power_good && !pg_q && !lnk.standby; // RQ15
  // floating reset pin is resolved to active by the pad model
  assign int_rst_b = rst_b && lnk.reset_b && !por_req && !cmd_rst; // RQ16
  // async assert, sync release so all state but pg_q leaves reset together
  always_ff @(posedge sys_clk or negedge int_rst_b) begin
    if (!int_rst_b) begin
      rst_meta_q <= 1'b0; // RQ21
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q; // RQ21
    end
  end
  assign my_addr = lnk.addr_sel ? SPMC_ADDR_HI : SPMC_ADDR_LO; // RQ20
  assign active = (st_q == SPMC_ST_READY) || (st_q == SPMC_ST_EXPOSE) ||
    (st_q == SPMC_ST_STREAM);
  assign hit = lnk.cmd_valid && (lnk.cmd_addr == my_addr) && active; // RQ1
  assign cmd_rst = hit && (lnk.cmd_op == SPMC_OP_RESET); // RQ16
  // divided tick: one line step every one, two or four clocks
  assign tick = (tick_q == ((div_q == SPMC_DIV_4) ? 2'h3 : div_q)); // RQ10
  always_comb begin
    st_d = st_q;
    rec_d = rec_q;
    cnt_d = cnt_q;
    nfrm_d = nfrm_q;
    expo_d = expo_q;
    lines_d = lines_q;
    vstart_d = vstart_q;
    frm_d = frm_q;
    line_d = line_q;
    div_d = div_q;
    view_d = view_q;
    snap_d = snap_q;
    fast_d = fast_q;
    bin_d = bin_q;
    ack_d = hit;
    lv_d = 1'b0;
    half_d = half_q;
    pix_d = pix_q;
    acc_d = acc_q;
    tick_d = tick ? 2'h0 : tick_q + 2'h1;
    if (hit) begin // RQ2
      unique case (lnk.cmd_op)
        SPMC_OP_REC_A: rec_d = SPMC_REC_A;
        SPMC_OP_REC_B: rec_d = SPMC_REC_B;
        SPMC_OP_REC_IDLE: rec_d = SPMC_REC_IDLE; // RQ7
        SPMC_OP_DIV: div_d = lnk.cmd_arg[1:0]; // RQ10
        SPMC_OP_NFRM: nfrm_d = lnk.cmd_arg; // RQ11
        SPMC_OP_EXPO: expo_d = lnk.cmd_arg;
        SPMC_OP_LINES: lines_d = lnk.cmd_arg; // RQ14
        SPMC_OP_VSTART: vstart_d = lnk.cmd_arg; // RQ14
        SPMC_OP_FAST: fast_d = lnk.cmd_arg[0]; // RQ12
        SPMC_OP_BIN: bin_d = lnk.cmd_arg[0]; // RQ18
        SPMC_OP_VIEW: begin
          view_d = 1'b1; // RQ9
          snap_d = 1'b0;
        end
        SPMC_OP_SNAP: begin
          snap_d = 1'b1;
          view_d = 1'b0;
          frm_d = '0;
          line_d = vstart_q;
          // fast reset shortens the line-reset sweep to a fixed overhead
          cnt_d = fast_q ? SPMC_CNT_W'(SPMC_FAST_OVH) :
            expo_q + SPMC_CNT_W'(SPMC_FAST_OVH); // RQ13
          if (st_q != SPMC_ST_READY) begin
            st_d = SPMC_ST_READY;
          end
        end
        SPMC_OP_STOP: begin
          view_d = 1'b0;
          snap_d = 1'b0;
          st_d = SPMC_ST_READY;
        end
        default: ;
      endcase
    end
    unique case (st_q)
      SPMC_ST_STANDBY: begin
        cnt_d = SPMC_CNT_W'(SETTLE_CYC);
        if (!lnk.standby) begin
          st_d = SPMC_ST_SETTLE;
        end
      end
      SPMC_ST_SETTLE: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0) begin
          st_d = SPMC_ST_RESET;
          cnt_d = SPMC_CNT_W'(SPMC_RST_HOLD);
        end
      end
      SPMC_ST_RESET: begin
        // mandatory clear of record and mode settings before normal operation
        cnt_d = cnt_q - 1'b1; // RQ4
        rec_d = SPMC_REC_A;
        view_d = 1'b0;
        snap_d = 1'b0;
        if (cnt_q == '0) begin
          st_d = SPMC_ST_READY; // RQ5
        end
      end
      SPMC_ST_READY: begin
        if ((view_q || snap_q) && rec_q != SPMC_REC_IDLE) begin // RQ8
          st_d = snap_q ? SPMC_ST_EXPOSE : SPMC_ST_STREAM;
          line_d = vstart_q; // RQ14
        end
      end
      SPMC_ST_EXPOSE: begin
        if (tick) begin
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == '0) begin
            st_d = SPMC_ST_STREAM; // RQ13
          end
        end
      end
      SPMC_ST_STREAM: begin
        if (rec_q == SPMC_REC_IDLE || !(view_q || snap_q)) begin
          st_d = SPMC_ST_READY; // RQ8
        end else if (tick) begin
          lv_d = 1'b1;
          // binning folds each same-colour pair into one output word
          if (bin_q && view_q) begin // RQ17
            half_d = !half_q;
            acc_d = half_q ? acc_q : pix_in;
            pix_d = half_q ? acc_q + pix_in : pix_q;
            lv_d = half_q;
          end else begin
            pix_d = pix_in;
          end
          line_d = line_q + 1'b1;
          if (line_q + 1'b1 >= lines_q + vstart_q) begin // RQ14
            line_d = vstart_q;
            frm_d = frm_q + 1'b1;
            // snapshot ends after its count; viewfinder runs on
            if (snap_q && frm_q + 1'b1 >= nfrm_q) begin // RQ11
              snap_d = 1'b0;
              st_d = SPMC_ST_READY;
            end
          end
        end
      end
      default: st_d = SPMC_ST_STANDBY;
    endcase
    if (lnk.standby) begin
      st_d = SPMC_ST_STANDBY; // RQ3
    end
  end
  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q <= SPMC_ST_STANDBY;
      rec_q <= SPMC_REC_A;
      cnt_q <= '0;
      nfrm_q <= SPMC_CNT_W'(1);
      expo_q <= '0;
      lines_q <= SPMC_CNT_W'(SPMC_LINE_CYC);
      vstart_q <= '0;
      frm_q <= '0;
      line_q <= '0;
      div_q <= SPMC_DIV_1;
      tick_q <= 2'h0;
      view_q <= 1'b0;
      snap_q <= 1'b0;
      fast_q <= 1'b0;
      bin_q <= 1'b0;
      ack_q <= 1'b0;
      lv_q <= 1'b0;
      half_q <= 1'b0;
      pix_q <= '0;
      acc_q <= '0;
    end else begin
      st_q <= st_d;
      rec_q <= rec_d;
      cnt_q <= cnt_d;
      nfrm_q <= nfrm_d;
      expo_q <= expo_d;
      lines_q <= lines_d;
      vstart_q <= vstart_d;
      frm_q <= frm_d;
      line_q <= line_d;
      div_q <= div_d;
      tick_q <= tick_d;
      view_q <= view_d;
      snap_q <= snap_d;
      fast_q <= fast_d;
      bin_q <= bin_d;
      ack_q <= ack_d;
      lv_q <= lv_d;
      half_q <= half_d;
      pix_q <= pix_d;
      acc_q <= acc_d;
    end
  end
  assign lnk.out_oe = (st_q != SPMC_ST_STANDBY) && !lnk.standby; // RQ3
  assign lnk.cmd_ack = ack_q;
  assign lnk.cmd_ack_oe = ack_q && lnk.out_oe; // RQ3
  assign lnk.frame_valid = (st_q == SPMC_ST_STREAM) && lnk.out_oe; // RQ9
  assign lnk.line_valid = lv_q && lnk.frame_valid;
  assign lnk.pix_data = pix_q;
  assign lnk.ready = active;
  assign core_power_on = lnk.out_oe; // RQ3
  // idle record: analog zero bias, slowest clock
  assign analog_bias = !lnk.out_oe ? 2'h1 :
    (rec_q == SPMC_REC_IDLE) ? 2'h0 : (snap_q ? 2'h3 : 2'h2); // RQ7
  assign clk_div = (rec_q == SPMC_REC_IDLE) ? SPMC_DIV_4 : div_q; // RQ7
  assign view_mode = view_q;
  assign snap_mode = snap_q;
  assign fast_reset = fast_q && (st_q == SPMC_ST_EXPOSE); // RQ12
endmodule
`default_nettype wire

/* File: src/spmc_host.sv */
// host end: pin sequencing and paced serial commands
`timescale 1ns/100ps
`default_nettype none
module spmc_host
  import spmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  spmc_link_if.host lnk,
  input wire logic power_up,
  input wire logic addr_pick,
  input wire logic req_valid,
  input wire logic [7:0] req_op,
  input wire logic [SPMC_CNT_W-1:0] req_arg,
  output logic req_ready,
  output logic dev_ready
);
  typedef enum logic [1:0] {
    SPMC_H_OFF = 2'b00,
    SPMC_H_RST = 2'b01,
    SPMC_H_ON = 2'b10
  } spmc_hst_t;
  spmc_hst_t hs_q, hs_d;
  logic [7:0] pace_q, pace_d;
  logic vld_q, vld_d;
  logic [7:0] op_q, op_d;
  logic [SPMC_CNT_W-1:0] arg_q, arg_d;

  always_comb begin
    hs_d = hs_q;
    pace_d = (pace_q == 8'h00) ? 8'h00 : pace_q - 8'h01;
    vld_d = 1'b0;
    op_d = op_q;
    arg_d = arg_q;
    unique case (hs_q)
      SPMC_H_OFF: if (power_up) hs_d = SPMC_H_RST;
      // reset is applied before standby is let go
      SPMC_H_RST: hs_d = SPMC_H_ON; // RQ6
      SPMC_H_ON: if (!power_up) hs_d = SPMC_H_OFF;
      default: hs_d = SPMC_H_OFF;
    endcase
    if (req_ready && req_valid) begin
      vld_d = 1'b1;
      op_d = req_op;
      arg_d = req_arg;
      pace_d = 8'(SPMC_SER_CYC); // RQ19
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hs_q <= SPMC_H_OFF;
      pace_q <= 8'h00;
      vld_q <= 1'b0;
      op_q <= 8'h00;
      arg_q <= '0;
    end else begin
      hs_q <= hs_d;
      pace_q <= pace_d;
      vld_q <= vld_d;
      op_q <= op_d;
      arg_q <= arg_d;
    end
  end

  assign lnk.standby = (hs_q == SPMC_H_OFF);
  assign lnk.reset_b = (hs_q == SPMC_H_ON); // RQ6
  assign lnk.reset_drv = 1'b1;
  assign lnk.addr_sel = addr_pick;
  assign lnk.cmd_valid = vld_q;
  assign lnk.cmd_op = op_q;
  assign lnk.cmd_arg = arg_q;
  assign lnk.cmd_addr = addr_pick ? SPMC_ADDR_HI : SPMC_ADDR_LO;
  // binning advice is left to the caller's command choice
  assign req_ready = (pace_q == 8'h00) && lnk.ready && !vld_q; // RQ19
  assign dev_ready = lnk.ready;
endmodule
`default_nettype wire

/* File: test/spmc_link_asserts.sv */
// link checker for the sensor power and mode control
`timescale 1ns/100ps
`default_nettype none
module spmc_link_asserts
  import spmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic reset_b,
  input wire logic addr_sel,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_ack,
  input wire logic cmd_ack_oe,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic out_oe,
  input wire logic ready,
  input wire logic core_power_on,
  input wire logic [1:0] analog_bias
);
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [21:0] wake_q;
  logic [21:0] wake_d;
  logic [6:0] own;
  assign own = addr_sel ? SPMC_ADDR_HI : SPMC_ADDR_LO;
  // saturates so a long quiet spell never wraps into a false gap
  always_comb begin
    gap_d = cmd_valid ? 8'h01 : gap_q + {7'h00, gap_q != 8'hff};
    wake_d = (standby || ready) ? '0 : wake_q + 22'h1;
  end
  always_ff @(posedge sys_clk) begin
    gap_q <= rst_b ? gap_d : 8'hff;
    wake_q <= rst_b ? wake_d : '0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_stby_pins_off: assert property (
    standby && $past(standby) |-> !out_oe && !cmd_ack_oe)
    else $error("pins driven in standby");
  chk_stby_low_bias: assert property (
    standby && $past(standby) |-> analog_bias == 2'h1 && !core_power_on)
    else $error("core alive in standby");
  chk_ack_has_cause: assert property (
    cmd_ack |-> $past(cmd_valid) && $past(ready) && $past(cmd_addr == own))
    else $error("ack without accepted command");
  chk_cmd_acked: assert property (
    cmd_valid && ready && cmd_addr == own && cmd_op != SPMC_OP_RESET
    |=> cmd_ack ##1 !cmd_ack) else $error("command not acked once");
  chk_cmd_spacing: assert property (
    cmd_valid |-> gap_q >= SPMC_SER_CYC) else $error("commands too close");
  chk_wake_budget: assert property (
    wake_q < SPMC_WAKE_CYC_L) else $error("standby exit too slow");
  chk_pin_reset_holds: assert property (
    !reset_b |=> !ready) else $error("ready while reset pin low");
  chk_reset_release: assert property (
    $rose(reset_b) |-> !ready [*2]) else $error("ready during reset release");
  chk_idle_no_image: assert property (
    analog_bias == 2'h0 && $past(analog_bias) == 2'h0
    |-> !frame_valid && !line_valid) else $error("image in idle record");
  chk_frame_driven: assert property (
    frame_valid |-> out_oe && !standby) else $error("frame with pins off");
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench joining host and sensor ends
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import spmc_pkg::*;
;
  logic sys_clk, rst_b, power_up, addr_pick, req_valid, req_ready, dev_ready;
  logic power_good, core_power_on, view_mode, snap_mode, fast_reset;
  logic ack_q = 1'b0;
  logic [7:0] req_op;
  logic [SPMC_CNT_W-1:0] req_arg;
  logic [SPMC_PIX_W-1:0] pix_in;
  logic [1:0] analog_bias, clk_div;
  logic [31:0] seed;
  logic [23:0] exp_q[$], pix_q[$];
  int fail_count, checks_done, n, m, i, ln;
  spmc_link_if lnk();
  spmc_host i_spmc_host(.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk),
    .power_up(power_up), .addr_pick(addr_pick), .req_valid(req_valid),
    .req_op(req_op), .req_arg(req_arg), .req_ready(req_ready),
    .dev_ready(dev_ready));
  // short settle keeps every wake well inside the run budget
  spmc_dev #(.SETTLE_CYC(10)) i_spmc_dev(.sys_clk(sys_clk), .rst_b(rst_b),
    .lnk(lnk), .power_good(power_good), .pix_in(pix_in),
    .core_power_on(core_power_on), .analog_bias(analog_bias),
    .clk_div(clk_div), .view_mode(view_mode), .snap_mode(snap_mode),
    .fast_reset(fast_reset));
  spmc_link_asserts i_spmc_link_asserts(.sys_clk(sys_clk), .rst_b(rst_b),
    .standby(lnk.standby), .reset_b(lnk.reset_b), .addr_sel(lnk.addr_sel),
    .cmd_valid(lnk.cmd_valid), .cmd_op(lnk.cmd_op),
    .cmd_addr(lnk.cmd_addr), .cmd_ack(lnk.cmd_ack),
    .cmd_ack_oe(lnk.cmd_ack_oe), .frame_valid(lnk.frame_valid),
    .line_valid(lnk.line_valid), .out_oe(lnk.out_oe), .ready(lnk.ready),
    .core_power_on(core_power_on), .analog_bias(analog_bias));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return dev_ready;
      1: return lnk.frame_valid;
      default: return fast_reset;
    endcase
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // bounded wait; n keeps the cycles taken for frame length checks
  task automatic wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    cmp("wait", v, sig(k));
    if (sig(k) !== v)
      results();
  endtask
  task automatic quiet(input int c);
    m = 0;
    repeat (c) begin
      @(posedge sys_clk);
      m = m | (lnk.frame_valid !== 1'b0);
    end
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] arg);
    int k;
    k = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_arg <= arg;
    do begin
      @(posedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 500);
    req_valid <= 1'b0;
    cmp("req_ready", 1, req_ready);
    if (req_ready !== 1'b1)
      results();
    if (op != SPMC_OP_RESET)
      exp_q.push_back(24'h1);
  endtask
  // results come one cycle after the command strobe, pixels on the strobe
  always @(posedge sys_clk) begin
    if (ack_q && exp_q.size() > 0)
      cmp("ack", exp_q.pop_front(), lnk.cmd_ack);
    if (lnk.line_valid === 1'b1 && pix_q.size() > 0)
      cmp("pix", pix_q.pop_front(), lnk.pix_data);
    ack_q <= lnk.cmd_valid;
  end
  initial begin
    {rst_b, power_up, addr_pick, req_valid} = '0;
    power_good = 1'b1;
    req_op = '0;
    req_arg = '0;
    pix_in = '0;
    seed = 32'h2031_13b7;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 2; i++) begin
      power_up <= 1'b0;
      tick(20);
      cmp("out_oe", 0, lnk.out_oe);
      cmp("bias", 1, analog_bias);
      cmp("core", 0, core_power_on);
      power_up <= 1'b1;
      wait_sig(0, 1, 20000);
      cmp("core", 1, core_power_on);
    end
    send(SPMC_OP_VIEW, 0);
    wait_sig(1, 1, 5000);
    cmp("view", 1, view_mode);
    cmp("vbias", 2, analog_bias);
    for (i = 1; i < 3; i++) begin
      send(SPMC_OP_DIV, i);
      tick(4);
      cmp("div", i, clk_div);
    end
    send(SPMC_OP_DIV, 0);
    send(SPMC_OP_STOP, 0);
    send(SPMC_OP_REC_IDLE, 0);
    tick(4);
    cmp("ibias", 0, analog_bias);
    cmp("idiv", SPMC_DIV_4, clk_div);
    send(SPMC_OP_VIEW, 0);
    quiet(300);
    cmp("iframe", 0, m);
    send(SPMC_OP_STOP, 0);
    send(SPMC_OP_REC_A, 0);
    send(SPMC_OP_EXPO, 5);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      ln = 4 + (i % 2) * 8 + seed[2:0];
      send(SPMC_OP_FAST, 24'(i / 2));
      // last pass: two frames from a shifted window
      send(SPMC_OP_NFRM, 24'(1 + i / 2));
      send(SPMC_OP_VSTART, 24'(i * 3));
      send(SPMC_OP_LINES, 24'(ln));
      send(SPMC_OP_SNAP, 0);
      if (i == 2)
        wait_sig(2, 1, 20);
      wait_sig(1, 1, 5 + SPMC_FAST_OVH + 8);
      cmp("snap", 1, snap_mode);
      cmp("sbias", 3, analog_bias);
      wait_sig(1, 0, 5000);
      cmp("lines", ln * (1 + i / 2), n);
      if (i == 1)
        cmp("window", 1, n > m);
      m = n;
      quiet(200);
      cmp("nfrm", 0, m);
      m = n;
    end
    send(SPMC_OP_FAST, 0);
    seed = lfsr(seed);
    pix_in <= seed[9:0];
    send(SPMC_OP_BIN, 1);
    send(SPMC_OP_VIEW, 0);
    wait_sig(1, 1, 5000);
    repeat (4) pix_q.push_back({14'h0, seed[8:0], 1'b0});
    tick(200);
    cmp("pix_left", 0, pix_q.size());
    send(SPMC_OP_STOP, 0);
    send(SPMC_OP_BIN, 0);
    addr_pick <= 1'b1;
    send(SPMC_OP_RESET, 0);
    wait_sig(0, 0, 60);
    wait_sig(0, 1, 200);
    send(SPMC_OP_REC_B, 0);
    power_good <= 1'b0;
    tick(3);
    power_good <= 1'b1;
    wait_sig(0, 0, 20);
    wait_sig(0, 1, 200);
    tick(60);
    cmp("ack_left", 0, exp_q.size());
    results();
  end
endmodule
`default_nettype wire
